// ---- hw/lhirq_core.sv ----
// Host interrupt request logic for mailbox channels and serial port
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// RULE_01: Fifteen host interrupt kinds on one line
// RULE_02: Kind 1 and 12 from channel 1 or UART
// RULE_03: SMI,6,9,10,11 from channels 2-4 or UART
// RULE_04: Remaining kinds only from the UART
// RULE_05: Linked mode: host read clears enable bit
// RULE_06: Direct mode: request from enables only
// RULE_07: Direct mode: software writes 0 to withdraw
// RULE_08: Clearing carrier change flag withdraws UART request
// RULE_09: Kind 1: write, read 0, write 1
// RULE_10: Kind 12 same sequence, own enable bit
// RULE_11: Linked SMI per source, cleared by read
// RULE_12: Direct SMI set read0/write1, clear write0
// RULE_13: Linked legacy kinds per channel 2-4
// RULE_14: Direct legacy kinds cleared only by write0
// RULE_15: UART selects kind, carrier change raises it
// RULE_16: Full flags guard data register access
// RULE_17: Write grants checked before bidir bytes
// RULE_18: Channel 3 decode for base A24F
// RULE_19: Channel 3 decode for base 3FD0
// RULE_20: OR all sources of each kind
module lhirq_core import lhirq_pkg::*; (
    input wire logic clock_in,
    input wire logic arst_n_in,
    input wire logic [7:0] reg_addr_in,
    input wire logic [7:0] reg_wdata_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    input wire logic lclk_in,
    input wire logic host_rd_in,
    input wire logic host_wr_in,
    input wire logic [15:0] host_addr_in,
    input wire logic carrier_detect_input_in,
    output logic [7:0] reg_rdata_out,
    output logic [15:0] host_irq_line_out,
    output logic [4:0] output_full_flag_out,
    output logic host_write_grant_flag_out,
    output logic local_write_grant_flag_out
);

    // ****************************************************************
    // Helpers
    // ****************************************************************
    // Source whose output-full flag steers enable bit i
    function automatic logic [2:0] src_of(input int unsigned i);
        logic [2:0] s;
        s = SRC_CH4;
        if (i < 2) begin
            s = SRC_CH1;
        end else if (i == 2 || (i >= 8 && i < 12)) begin
            s = SRC_CH2;
        end else if (i == 3 || (i >= 12 && i < 16)) begin
            s = SRC_CH3;
        end else if (i == 4) begin
            s = SRC_BIDIR;
        end
        return s;
    endfunction : src_of

    // Channel index of a source, the bidir bytes belong to channel 3
    function automatic logic [1:0] chan_of(input logic [2:0] s);
        logic [1:0] c;
        c = 2'h3;
        if (s == SRC_CH1) begin
            c = 2'h0;
        end else if (s == SRC_CH2) begin
            c = 2'h1;
        end else if (s == SRC_CH3 || s == SRC_BIDIR) begin
            c = 2'h2;
        end
        return c;
    endfunction : chan_of

    // Host interrupt kind of enable bit i
    function automatic logic [3:0] kind_of(input int unsigned i);
        logic [3:0] k;
        logic [1:0] n;
        k = KIND_SMI;
        n = 2'(i % 4);
        if (i == 0) begin
            k = 4'h1;
        end else if (i == 1) begin
            k = 4'hC;
        end else if (i >= 8) begin
            unique case (n)
                2'h0: k = 4'h6;
                2'h1: k = 4'h9;
                2'h2: k = 4'hA;
                2'h3: k = 4'hB;
            endcase
        end
        return k;
    endfunction : kind_of

    // ****************************************************************
    // Pin synchronisation
    // ****************************************************************
    lhirq_host_cyc_t cyc;
    logic carrier;

    lhirq_pin_sync u_sync (
        .clock_in(clock_in),
        .arst_n_in(arst_n_in),
        .lclk_in(lclk_in),
        .host_rd_in(host_rd_in),
        .host_wr_in(host_wr_in),
        .host_addr_in(host_addr_in),
        .carrier_detect_input_in(carrier_detect_input_in),
        .cyc_out(cyc),
        .carrier_out(carrier)
    );

    // ****************************************************************
    // State
    // ****************************************************************
    logic [4:0] of_r;
    logic [4:0] of_nxt;

    logic [23:0] en_r;
    logic [23:0] en_nxt;

    // Set by a read of 0, dropped by any write to its enable register
    logic [23:0] arm_r;
    logic [23:0] arm_nxt;

    logic [3:0] dir_r;
    logic [3:0] uart_sel_r;
    logic [15:0] ch3_base_r;

    logic host_grant_r;
    logic local_grant_r;

    logic carrier_prev_r;
    logic change_r;

    logic [15:0] irq_nxt;

    // ****************************************************************
    // Host address decode
    // ****************************************************************
    wire logic [15:0] ch3_data_addr = ch3_base_r & ~CH3_DATA_CLR; // see RULE_18 see RULE_19
    wire logic [15:0] ch3_hdr_addr = {ch3_base_r[15:4], 4'h0} ^ CH3_HDR_FLIP; // see RULE_18 see RULE_19
    wire logic [15:0] ch3_last_addr = ch3_hdr_addr | CH3_LAST_OFS; // see RULE_18 see RULE_19

    // Taken once per link clock rise
    wire logic h_rd = cyc.valid & cyc.rd;
    wire logic h_wr = cyc.valid & cyc.wr;
    wire logic [4:0] h_rd_hit = {
        h_rd & (cyc.addr == CH4_HOST_ADDR),
        h_rd & (cyc.addr == ch3_last_addr),
        h_rd & (cyc.addr == ch3_data_addr),
        h_rd & (cyc.addr == CH2_HOST_ADDR),
        h_rd & (cyc.addr == CH1_HOST_ADDR)
    };

    wire logic h_hdr_wr = h_wr & (cyc.addr == ch3_hdr_addr);
    wire logic h_last_wr = h_wr & (cyc.addr == ch3_last_addr);

    // ****************************************************************
    // Local register decode
    // ****************************************************************
    wire logic w_hdr = reg_wr_in & (reg_addr_in == OFS_BIDIR_HDR);
    wire logic w_last = reg_wr_in & (reg_addr_in == OFS_BIDIR_LAST);
    wire logic w_ctrl = reg_wr_in & (reg_addr_in == OFS_CTRL);
    wire logic w_usel = reg_wr_in & (reg_addr_in == OFS_UART_SEL);
    wire logic w_msr = reg_wr_in & (reg_addr_in == OFS_MSR);
    wire logic w_blo = reg_wr_in & (reg_addr_in == OFS_BASE_LO);
    wire logic w_bhi = reg_wr_in & (reg_addr_in == OFS_BASE_HI);

    wire logic [2:0] w_en = {
        reg_wr_in & (reg_addr_in == OFS_EN_C),
        reg_wr_in & (reg_addr_in == OFS_EN_B),
        reg_wr_in & (reg_addr_in == OFS_EN_A)
    };

    // Enable reads arm the zero bits
    wire logic [2:0] r_en = {
        reg_rd_in & (reg_addr_in == OFS_EN_C),
        reg_rd_in & (reg_addr_in == OFS_EN_B),
        reg_rd_in & (reg_addr_in == OFS_EN_A)
    };

    // Bidir last byte from the local side needs the local grant
    wire logic [4:0] cpu_set = {
        reg_wr_in & (reg_addr_in == OFS_OUT4),
        w_last & local_grant_r, // see RULE_17
        reg_wr_in & (reg_addr_in == OFS_OUT3),
        reg_wr_in & (reg_addr_in == OFS_OUT2),
        reg_wr_in & (reg_addr_in == OFS_OUT1)
    };

    // ****************************************************************
    // Output-full flags and write grants
    // ****************************************************************
    // A host read in the same cycle as a local write loses
    assign of_nxt = cpu_set | (of_r & ~h_rd_hit); // see RULE_16

    // Host keeps priority when both sides claim in one cycle
    wire logic host_grant_nxt = (h_hdr_wr & ~local_grant_r)
                              | (host_grant_r & ~h_last_wr); // see RULE_17
    wire logic local_grant_nxt = (w_hdr & ~host_grant_r & ~h_hdr_wr)
                               | (local_grant_r & ~w_last); // see RULE_17

    // ****************************************************************
    // Enable bits: read 0 arms, write 1 sets, write 0 clears
    // ****************************************************************
    always_comb begin
        logic [2:0] s;
        logic direct;
        logic wbit;
        s = SRC_CH1;
        direct = 1'b0;
        wbit = 1'b0;
        en_nxt = en_r;
        arm_nxt = arm_r;
        for (int unsigned i = 0; i < NUM_EN; i++) begin
            s = src_of(i);
            direct = dir_r[chan_of(s)];
            wbit = reg_wdata_in[i % 8];
            // Linked mode drops the enable once the host empties the source
            if (!direct && of_r[s] && h_rd_hit[s]) begin
                en_nxt[i] = 1'b0; // see RULE_05 see RULE_11 see RULE_13
            end
            if (r_en[i / 8]) begin
                arm_nxt[i] = ~en_r[i];
            end
            if (w_en[i / 8]) begin
                arm_nxt[i] = 1'b0;
                if (!wbit) begin
                    en_nxt[i] = 1'b0; // see RULE_07 see RULE_12 see RULE_14
                end else if (arm_r[i] && (direct || of_r[s])) begin
                    // Set wins over a host read in the same cycle
                    en_nxt[i] = 1'b1; // see RULE_09 see RULE_10 see RULE_06
                end
            end
        end

        // Unused positions stay 0
        en_nxt = en_nxt & EN_MASK;
        arm_nxt = arm_nxt & EN_MASK;
    end

    // ****************************************************************
    // Carrier change flag of the serial port
    // ****************************************************************
    wire logic carrier_edge = carrier ^ carrier_prev_r;
    wire logic change_clr = w_msr & ~reg_wdata_in[MSR_CHANGE];
    wire logic change_nxt = carrier_edge | (change_r & ~change_clr); // see RULE_08

    // ****************************************************************
    // Request merge per host interrupt kind
    // ****************************************************************
    wire logic [15:0] uart_vec = (change_r && uart_sel_r != 4'h0)
                               ? (16'h0001 << uart_sel_r) : 16'h0000; // see RULE_15

    always_comb begin
        irq_nxt = uart_vec; // see RULE_04
        // Kind 2 has no frame: serial kind 2 is SMI
        irq_nxt[KIND_SMI] = uart_vec[KIND_UART_SMI];
        irq_nxt[KIND_UART_SMI] = 1'b0; // see RULE_01

        for (int unsigned i = 0; i < NUM_EN; i++) begin
            // Mailbox kinds come only from their allowed channels
            irq_nxt[kind_of(i)] = irq_nxt[kind_of(i)]
                                | en_r[i]; // see RULE_20 see RULE_02 see RULE_03
        end
    end

    // ****************************************************************
    // Read data mux
    // ****************************************************************
    wire logic [7:0] status_val = {1'b0, local_grant_r, host_grant_r, of_r};
    // Zero outside the cycle after a read
    wire logic [7:0] rdata_nxt =
        !reg_rd_in ? 8'h00 :
        (reg_addr_in == OFS_STATUS) ? status_val :
        (reg_addr_in == OFS_CTRL) ? {4'h0, dir_r} :
        (reg_addr_in == OFS_EN_A) ? en_r[7:0] :
        (reg_addr_in == OFS_EN_B) ? en_r[15:8] :
        (reg_addr_in == OFS_EN_C) ? en_r[23:16] :
        (reg_addr_in == OFS_UART_SEL) ? {4'h0, uart_sel_r} :
        (reg_addr_in == OFS_MSR) ? {carrier, 6'h00, change_r} :
        (reg_addr_in == OFS_BASE_LO) ? ch3_base_r[7:0] :
        (reg_addr_in == OFS_BASE_HI) ? ch3_base_r[15:8] : 8'h00;

    // ****************************************************************
    // Registers
    // ****************************************************************
    always_ff @(posedge clock_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            of_r <= 5'h00;
            en_r <= 24'h000000;
            arm_r <= 24'h000000;
            host_grant_r <= 1'b0;
            local_grant_r <= 1'b0;
            carrier_prev_r <= 1'b0;
            change_r <= 1'b0;
        end else begin
            of_r <= of_nxt;
            en_r <= en_nxt;
            arm_r <= arm_nxt;
            host_grant_r <= host_grant_nxt;
            local_grant_r <= local_grant_nxt;
            carrier_prev_r <= carrier;
            change_r <= change_nxt;
        end
    end

    // Software set-up registers
    always_ff @(posedge clock_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            dir_r <= CTRL_RST;
            uart_sel_r <= UART_SEL_RST;
            ch3_base_r <= CH3_BASE_RST;
        end else begin
            dir_r <= w_ctrl ? reg_wdata_in[3:0] : dir_r;
            uart_sel_r <= w_usel ? reg_wdata_in[3:0] : uart_sel_r;
            ch3_base_r[7:0] <= w_blo ? reg_wdata_in : ch3_base_r[7:0];
            ch3_base_r[15:8] <= w_bhi ? reg_wdata_in : ch3_base_r[15:8];
        end
    end

    // Output copies of the next state
    always_ff @(posedge clock_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            reg_rdata_out <= 8'h00;
            host_irq_line_out <= 16'h0000;
            output_full_flag_out <= 5'h00;
            host_write_grant_flag_out <= 1'b0;
            local_write_grant_flag_out <= 1'b0;
        end else begin
            reg_rdata_out <= rdata_nxt;
            host_irq_line_out <= irq_nxt;
            output_full_flag_out <= of_nxt;
            host_write_grant_flag_out <= host_grant_nxt;
            local_write_grant_flag_out <= local_grant_nxt;
        end
    end

endmodule : lhirq_core
`default_nettype wire

// ---- hw/lhirq_pkg.sv ----
// Shared constants and types of the host interrupt request logic
package lhirq_pkg;

    // ****************************************************************
    // Local register offsets
    // ****************************************************************
    localparam logic [7:0] OFS_OUT1 = 8'h00;
    localparam logic [7:0] OFS_OUT2 = 8'h01;
    localparam logic [7:0] OFS_OUT3 = 8'h02;
    localparam logic [7:0] OFS_OUT4 = 8'h03;
    localparam logic [7:0] OFS_BIDIR_LAST = 8'h04;
    localparam logic [7:0] OFS_BIDIR_HDR = 8'h05;
    localparam logic [7:0] OFS_STATUS = 8'h08;
    localparam logic [7:0] OFS_CTRL = 8'h09;
    localparam logic [7:0] OFS_EN_A = 8'h0A;
    localparam logic [7:0] OFS_EN_B = 8'h0B;
    localparam logic [7:0] OFS_EN_C = 8'h0C;
    localparam logic [7:0] OFS_UART_SEL = 8'h0D;
    localparam logic [7:0] OFS_MSR = 8'h0E;
    localparam logic [7:0] OFS_BASE_LO = 8'h10;
    localparam logic [7:0] OFS_BASE_HI = 8'h11;

    // ****************************************************************
    // Field positions and reset values
    // ****************************************************************
    localparam int unsigned NUM_SRC = 5;
    localparam int unsigned NUM_EN = 24;
    localparam logic [23:0] EN_MASK = 24'h0FFF3F;
    localparam int unsigned ST_HOST_GRANT = 5;
    localparam int unsigned ST_LOCAL_GRANT = 6;
    localparam int unsigned MSR_CHANGE = 0;
    localparam int unsigned MSR_LEVEL = 7;
    localparam logic [3:0] CTRL_RST = 4'h0;
    localparam logic [3:0] UART_SEL_RST = 4'h0;
    localparam logic [15:0] CH3_BASE_RST = 16'hA24F;

    // ****************************************************************
    // Host address map
    // ****************************************************************
    localparam logic [15:0] CH1_HOST_ADDR = 16'h0060;
    localparam logic [15:0] CH2_HOST_ADDR = 16'h0062;
    localparam logic [15:0] CH4_HOST_ADDR = 16'h0068;
    localparam logic [15:0] CH3_DATA_CLR = 16'h0005;
    localparam logic [15:0] CH3_HDR_FLIP = 16'h0010;
    localparam logic [15:0] CH3_LAST_OFS = 16'h000F;

    // ****************************************************************
    // Sources of the output-full flags and host interrupt kinds
    // ****************************************************************
    localparam logic [2:0] SRC_CH1 = 3'h0;
    localparam logic [2:0] SRC_CH2 = 3'h1;
    localparam logic [2:0] SRC_CH3 = 3'h2;
    localparam logic [2:0] SRC_BIDIR = 3'h3;
    localparam logic [2:0] SRC_CH4 = 3'h4;
    localparam logic [3:0] KIND_SMI = 4'h0;
    localparam logic [3:0] KIND_UART_SMI = 4'h2;

    typedef struct packed {
        logic valid;
        logic rd;
        logic wr;
        logic [15:0] addr;
    } lhirq_host_cyc_t;

endpackage : lhirq_pkg

// ---- hw/lhirq_pin_sync.sv ----
// Pin synchroniser and link clock edge finder
`timescale 1ns/1ps
`default_nettype none
module lhirq_pin_sync import lhirq_pkg::*; (
    input wire logic clock_in,
    input wire logic arst_n_in,
    input wire logic lclk_in,
    input wire logic host_rd_in,
    input wire logic host_wr_in,
    input wire logic [15:0] host_addr_in,
    input wire logic carrier_detect_input_in,
    output var lhirq_host_cyc_t cyc_out,
    output logic carrier_out
);

    // ****************************************************************
    // Two flip-flop synchronisers
    // ****************************************************************
    logic [19:0] meta_r;
    logic [19:0] sync_r;
    logic lclk_prev_r;
    wire logic lclk_rise;

    assign lclk_rise = sync_r[19] & ~lclk_prev_r;

    always_ff @(posedge clock_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            meta_r <= 20'h00000;
            sync_r <= 20'h00000;
            lclk_prev_r <= 1'b0;
            cyc_out <= '0;
            carrier_out <= 1'b0;
        end else begin
            meta_r <= {lclk_in, carrier_detect_input_in, host_rd_in,
                       host_wr_in, host_addr_in};
            sync_r <= meta_r;
            lclk_prev_r <= sync_r[19];
            cyc_out <= '{valid: lclk_rise, rd: sync_r[17],
                         wr: sync_r[16], addr: sync_r[15:0]};
            carrier_out <= sync_r[18];
        end
    end

endmodule : lhirq_pin_sync
`default_nettype wire

// ---- testbench/lhirq_core_assertions.sv ----
// Port checker of the host interrupt request logic
`timescale 1ns/1ps
`default_nettype none
module lhirq_core_checker import lhirq_pkg::*; (
    input wire logic clock_in,
    input wire logic arst_n_in,
    input wire logic [7:0] reg_addr_in,
    input wire logic [7:0] reg_wdata_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    input wire logic lclk_in,
    input wire logic host_rd_in,
    input wire logic host_wr_in,
    input wire logic [15:0] host_addr_in,
    input wire logic carrier_detect_input_in,
    input wire logic [7:0] reg_rdata_out,
    input wire logic [15:0] host_irq_line_out,
    input wire logic [4:0] output_full_flag_out,
    input wire logic host_write_grant_flag_out,
    input wire logic local_write_grant_flag_out
);
    // Serial port kind selection, tracked from the register bus
    logic [3:0] sel_r;
    always_ff @(posedge clock_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            sel_r <= 4'h0;
        end else if (reg_wr_in && reg_addr_in == OFS_UART_SEL) begin
            sel_r <= reg_wdata_in[3:0];
        end
    end
    default clocking cb @(posedge clock_in); endclocking
    default disable iff (!arst_n_in);
    AST_NO_KIND_TWO: assert property (host_irq_line_out[2] == 1'b0)
        else $error("kind two request driven");
    AST_STATUS_READ: assert property (reg_rd_in && reg_addr_in == OFS_STATUS
        |=> reg_rdata_out == {1'b0, $past(local_write_grant_flag_out),
        $past(host_write_grant_flag_out), $past(output_full_flag_out)})
        else $error("status read differs from flag outputs");
    AST_OUT_FULL: assert property (reg_wr_in && reg_addr_in == OFS_OUT1
        |=> output_full_flag_out[0]) else $error("output flag not set");
    AST_GRANT_EXCL: assert property (!(host_write_grant_flag_out
        && local_write_grant_flag_out)) else $error("both write grants held");
    AST_LOCAL_GRANT: assert property (reg_wr_in
        && reg_addr_in == OFS_BIDIR_HDR && !host_write_grant_flag_out
        |=> local_write_grant_flag_out) else $error("local grant not taken");
    AST_UART_ONLY: assert property ((host_irq_line_out & 16'hE1B8
        & ~((16'h0001 << sel_r) | (16'h0001 << $past(sel_r)))) == 16'h0000)
        else $error("serial port only kind raised without selection");
    AST_KBD_SET: assert property ($rose(host_irq_line_out[1])
        && sel_r != 4'h1 |-> $past(reg_wr_in && reg_addr_in == OFS_EN_A
        && reg_wdata_in[0], 2)) else $error("kind one raised without enable");
    AST_MOUSE_SET: assert property ($rose(host_irq_line_out[12])
        && sel_r != 4'hC |-> $past(reg_wr_in && reg_addr_in == OFS_EN_A
        && reg_wdata_in[1], 2)) else $error("kind twelve raised without enable");
    AST_MSR_CLEAR: assert property (reg_wr_in && reg_addr_in == OFS_MSR
        && !reg_wdata_in[MSR_CHANGE] && $stable(carrier_detect_input_in)
        |-> ##[1:3] (host_irq_line_out & 16'hE1B8) == 16'h0000)
        else $error("serial port request kept after flag clear");
    cover property ($rose(host_irq_line_out[0]));
    cover property ($fell(output_full_flag_out[3]));
    cover property ($rose(host_write_grant_flag_out));
endmodule : lhirq_core_checker
bind lhirq_core lhirq_core_checker u_chk (.clock_in(clock_in),
    .arst_n_in(arst_n_in), .reg_addr_in(reg_addr_in),
    .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in),
    .reg_rd_in(reg_rd_in), .lclk_in(lclk_in), .host_rd_in(host_rd_in),
    .host_wr_in(host_wr_in), .host_addr_in(host_addr_in),
    .carrier_detect_input_in(carrier_detect_input_in),
    .reg_rdata_out(reg_rdata_out), .host_irq_line_out(host_irq_line_out),
    .output_full_flag_out(output_full_flag_out),
    .host_write_grant_flag_out(host_write_grant_flag_out),
    .local_write_grant_flag_out(local_write_grant_flag_out));
`default_nettype wire

// ---- testbench/lhirq_host_model.sv ----
// Host controller model: free link clock and host read and write cycles
`timescale 1ns/1ps
`default_nettype none
module lhirq_host_model (
    output logic lclk_out,
    output logic host_rd_out,
    output logic host_wr_out,
    output logic [15:0] host_addr_out
);
    initial begin
        lclk_out = 1'b0;
        host_rd_out = 1'b0;
        host_wr_out = 1'b0;
        host_addr_out = 16'h0000;
        forever #160 lclk_out = ~lclk_out;
    end
    // One cycle held over a whole rising edge; released address is inverted
    task automatic access(input logic rd, input logic wr, input logic [15:0] a);
        @(negedge lclk_out);
        host_addr_out <= a;
        host_rd_out <= rd;
        host_wr_out <= wr;
        @(negedge lclk_out);
        host_rd_out <= 1'b0;
        host_wr_out <= 1'b0;
        host_addr_out <= ~a;
    endtask : access
endmodule : lhirq_host_model
`default_nettype wire

// ---- testbench/testbench.sv ----
// Self-checking testbench of the host interrupt request logic
`timescale 1ns/1ps
`default_nettype none
`define CHECK(got, exp) begin num_checks++; if ((got) !== (exp)) begin \
    err_count++; $display("Error at %0t: got %0h expected %0h", $time, \
    got, exp); end end
module testbench import lhirq_pkg::*; ;
    logic clock_in = 1'b0;
    logic arst_n_in = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [7:0] wdata = 8'h00;
    logic wr = 1'b0;
    logic rd_stb = 1'b0;
    logic carrier = 1'b0;
    logic lclk;
    logic hrd;
    logic hwr;
    logic [15:0] haddr_w;
    logic [7:0] rdata;
    logic [15:0] irq;
    logic [4:0] full;
    logic hgrant;
    logic lgrant;
    logic [7:0] rd;
    int err_count = 0;
    int num_checks = 0;
    int lgcy [4] = '{6, 9, 10, 11};
    initial begin
        forever #20 clock_in = ~clock_in;
    end
    lhirq_host_model host (.lclk_out(lclk), .host_rd_out(hrd),
        .host_wr_out(hwr), .host_addr_out(haddr_w));
    lhirq_core DUT (.clock_in(clock_in), .arst_n_in(arst_n_in),
        .reg_addr_in(addr), .reg_wdata_in(wdata), .reg_wr_in(wr),
        .reg_rd_in(rd_stb), .lclk_in(lclk), .host_rd_in(hrd),
        .host_wr_in(hwr), .host_addr_in(haddr_w),
        .carrier_detect_input_in(carrier), .reg_rdata_out(rdata),
        .host_irq_line_out(irq), .output_full_flag_out(full),
        .host_write_grant_flag_out(hgrant),
        .local_write_grant_flag_out(lgrant));
    // ****************************************************************
    // Bus tasks and closing report
    // ****************************************************************
    task automatic tick(input int n);
        repeat (n) @(posedge clock_in);
        #1;
    endtask : tick
    task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
        @(posedge clock_in);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clock_in);
        wr <= 1'b0;
    endtask : reg_write
    task automatic reg_read(input logic [7:0] a, output logic [7:0] d);
        @(posedge clock_in);
        addr <= a;
        rd_stb <= 1'b1;
        @(posedge clock_in);
        rd_stb <= 1'b0;
        #1;
        d = rdata;
    endtask : reg_read
    task automatic complete_run;
        $display("Checks %0d, mismatches %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : complete_run
    function automatic logic [15:0] kind_bit(input int i);
        return 16'h0001 << ((i < 2) ? 1 + 11 * i : (i < 6) ? 0 :
            lgcy[i % 4 ^ 2]);
    endfunction : kind_bit
    // One mailbox source: refused set, armed set, host read, software clear
    task automatic run_case(input int i, input logic direct);
        logic [7:0] dat;
        logic [7:0] en_off;
        logic [7:0] en_val;
        logic [15:0] ha;
        logic [15:0] exp;
        int ch;
        int g;
        int ofb;
        g = (i - 6) / 4;
        ch = (i < 2) ? 0 : (i < 6) ? ((i == 2) ? 1 : (i == 5) ? 3 : 2) : g + 1;
        ofb = (i == 4) ? 3 : (ch == 3) ? 4 : ch;
        dat = (i == 4) ? OFS_BIDIR_LAST : OFS_OUT1 + 8'(ch);
        en_off = (i < 6) ? OFS_EN_A : (g == 2) ? OFS_EN_C : OFS_EN_B;
        en_val = (i < 6) ? 8'h01 << i : 8'h01 << ((i - 6) % 4 + 4 * (g % 2));
        exp = kind_bit(i);
        ha = (ch == 0) ? CH1_HOST_ADDR : (ch == 1) ? CH2_HOST_ADDR :
            (ch == 3) ? CH4_HOST_ADDR : (i == 4) ? 16'hA25F : 16'hA24A;
        reg_write(OFS_CTRL, direct ? 8'h0F : 8'h00);
        if (i == 4) begin
            reg_write(OFS_BIDIR_HDR, 8'h00);
        end
        reg_write(dat, 8'($urandom));
        reg_write(en_off, 8'h00);
        reg_write(en_off, en_val);
        tick(3);
        `CHECK(irq, 16'h0000)
        reg_read(en_off, rd);
        reg_write(en_off, en_val);
        tick(3);
        `CHECK(irq, exp)
        host.access(1'b1, 1'b0, ha);
        tick(8);
        `CHECK(full[ofb], 1'b0)
        `CHECK(irq, direct ? exp : 16'h0000)
        reg_read(en_off, rd);
        `CHECK(rd, direct ? en_val : 8'h00)
        reg_write(en_off, 8'h00);
        tick(3);
        `CHECK(irq, 16'h0000)
    endtask : run_case
    initial begin
        #1000000;
        err_count++;
        complete_run();
    end
    initial begin
        void'($urandom(67));
        repeat (20) @(posedge clock_in);
        arst_n_in <= 1'b1;
        tick(2);
        reg_read(OFS_BASE_HI, rd);
        `CHECK(rd, 8'hA2)
        reg_read(OFS_BASE_LO, rd);
        `CHECK(rd, 8'h4F)
        reg_read(8'h12 + 8'($urandom % 200), rd);
        `CHECK(rd, 8'h00)
        reg_read(OFS_STATUS, rd);
        `CHECK(rd, 8'h00)
        `CHECK(irq, 16'h0000)
        $display("Test reset done");
        for (int i = 0; i < 36; i++) begin
            run_case(i % 18, i > 17);
        end
        $display("Test mailbox done");
        for (int k = 1; k < 16; k++) begin
            reg_write(OFS_UART_SEL, 8'(k));
            carrier <= ~carrier;
            tick(8);
            `CHECK(irq, (k == 2) ? 16'h0001 : 16'h0001 << k)
            reg_read(OFS_MSR, rd);
            `CHECK(rd, {carrier, 7'h01})
            reg_write(OFS_MSR, 8'h00);
            tick(3);
            `CHECK(irq, 16'h0000)
        end
        reg_write(OFS_UART_SEL, 8'h00);
        $display("Test serial port done");
        reg_write(OFS_BASE_LO, 8'hD0);
        reg_write(OFS_BASE_HI, 8'h3F);
        reg_write(OFS_OUT3, 8'h5A);
        host.access(1'b1, 1'b0, 16'h3FD4);
        tick(8);
        `CHECK(full[2], 1'b1)
        host.access(1'b1, 1'b0, 16'h3FD0);
        tick(8);
        `CHECK(full[2], 1'b0)
        reg_write(OFS_BIDIR_HDR, 8'h00);
        tick(1);
        `CHECK({hgrant, lgrant}, 2'b01)
        reg_write(OFS_BIDIR_LAST, 8'hC3);
        tick(1);
        `CHECK({full[3], lgrant}, 2'b10)
        host.access(1'b1, 1'b0, 16'h3FCF);
        tick(8);
        `CHECK(full[3], 1'b0)
        host.access(1'b0, 1'b1, 16'h3FC0);
        tick(8);
        `CHECK(hgrant, 1'b1)
        reg_write(OFS_BIDIR_LAST, 8'h11);
        tick(1);
        `CHECK(full[3], 1'b0)
        host.access(1'b0, 1'b1, 16'h3FCF);
        tick(8);
        `CHECK(hgrant, 1'b0)
        $display("Test base and grants done");
        complete_run();
    end
endmodule : testbench
`default_nettype wire
